//--- nvm_access_regs.sv
// nvm data access registers: address, data and indirect control
`timescale 1ns/1ps
// Behaviour
// RL1: byte array of 32 (small) or 64 (large variant) locations.
// RL2: every transfer moves one byte; array not in the memory map.
// RL3: access controlled only by address, data and control registers.
// RL4: address and data registers sit in bank 0, directly addressed.
// RL5: control register at 40h of bank 1, only via indirect access.
// RL6: address register has 5 or 6 bits; upper bits read zero.
// RL7: bit3 permits writes; bit2 starts write, self-clears, needs bit3.
// RL8: bit1 permits reads; bit0 starts read, self-clears, needs bit1.
// RL9: a finished read loads the addressed byte into the data register.
module nvm_access_regs
    import nvm_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_direct_wr,
    input wire logic i_direct_rd,
    input wire logic [7:0] i_direct_addr,
    input wire logic i_indirect_wr,
    input wire logic i_indirect_rd,
    input wire logic [7:0] i_indirect_pointer_one,
    input wire logic [7:0] i_bank_select,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_busy
);
    localparam int ABITS = LARGE ? NVM_ABITS_LARGE : NVM_ABITS_SMALL; // RL1
    localparam logic [7:0] AMASK = LARGE ? 8'h3f : 8'h1f; // RL6
    localparam logic [7:0] CNT_ZERO = 8'h00;

    // direct addressing always lands in bank 0, whatever bank_select holds
    function automatic logic direct_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // a start bit only takes when its permit was set by an earlier write
    function automatic logic start_taken(input logic [7:0] wdata, input logic [3:0] ctl,
        input int start_bit, input int permit_bit);
        return wdata[start_bit] && ctl[permit_bit];
    endfunction

    // preload so that the last cycle of a phase is the one counted at zero
    function automatic logic [7:0] cycles_to_count(input int cycles);
        return 8'(cycles - 1);
    endfunction

    function automatic logic [7:0] count_down(input logic [7:0] cnt);
        return cnt - 8'h01;
    endfunction

    // upper control bits are unimplemented and read zero
    function automatic logic [7:0] ctl_view(input logic [3:0] ctl);
        return {4'h0, ctl};
    endfunction

    logic [7:0] nvm_address_q, nvm_address_d;
    logic [7:0] nvm_data_q, nvm_data_d;
    logic [3:0] nvm_control_q, nvm_control_d;
    logic [7:0] arr_rdata;
    logic arr_we;

    nvm_state_e state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic write_done, read_done;

    logic sel_addr, sel_data, sel_ctl;
    logic wr_addr, wr_data, wr_ctl;
    logic set_write_start, set_read_start;

    // strobes count only with their select matching
    assign sel_addr = direct_hit(i_direct_addr, NVM_ADDRESS_OFS); // RL4
    assign sel_data = direct_hit(i_direct_addr, NVM_DATA_OFS); // RL4
    assign sel_ctl = (i_indirect_pointer_one == NVM_CONTROL_OFS)
        && (i_bank_select == NVM_CONTROL_BANK); // RL5

    assign wr_addr = i_direct_wr && sel_addr;
    assign wr_data = i_direct_wr && sel_data;
    assign wr_ctl = i_indirect_wr && sel_ctl;
    assign set_write_start = wr_ctl
        && start_taken(i_wdata, nvm_control_q, CTL_WRITE_START, CTL_WRITE_PERMIT); // RL7
    assign set_read_start = wr_ctl
        && start_taken(i_wdata, nvm_control_q, CTL_READ_START, CTL_READ_PERMIT); // RL8

    nvm_array #(.ABITS(ABITS)) u_array (
        .i_ref_clk(i_ref_clk),
        .i_we(arr_we),
        .i_addr(nvm_address_q[ABITS-1:0]),
        .i_wdata(nvm_data_q),
        .o_rdata(arr_rdata)
    ); // RL2

    // sequencer; write wins if both start bits are pending
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        arr_we = 1'b0;
        write_done = 1'b0;
        read_done = 1'b0;
        case (state_q)
            NVM_IDLE: begin
                if (nvm_control_q[CTL_WRITE_START]) begin
                    state_d = NVM_WRITE;
                    cnt_d = cycles_to_count(WRITE_CYCLES);
                    arr_we = 1'b1; // RL7
                end else if (nvm_control_q[CTL_READ_START]) begin
                    state_d = NVM_READ;
                    cnt_d = cycles_to_count(READ_CYCLES);
                end
            end
            NVM_WRITE: begin
                // the array took the byte on entry; this only times the cycle
                if (cnt_q == CNT_ZERO) begin
                    write_done = 1'b1; // RL7
                    state_d = NVM_IDLE;
                end else begin
                    cnt_d = count_down(cnt_q);
                end
            end
            NVM_READ: begin
                // registered array output has settled by the zero count
                if (cnt_q == CNT_ZERO) begin
                    read_done = 1'b1; // RL8
                    state_d = NVM_IDLE;
                end else begin
                    cnt_d = count_down(cnt_q);
                end
            end
            default: begin
                state_d = NVM_IDLE;
                cnt_d = CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_q <= NVM_IDLE;
            cnt_q <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // address register: software writes only
    always_comb begin
        nvm_address_d = nvm_address_q;
        if (wr_addr) begin
            nvm_address_d = i_wdata & AMASK; // RL6
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            nvm_address_q <= ADDR_RESET;
        end else begin
            nvm_address_q <= nvm_address_d;
        end
    end

    // a finishing read wins over a software write in the same cycle
    always_comb begin
        nvm_data_d = nvm_data_q;
        if (read_done) begin
            nvm_data_d = arr_rdata; // RL9
        end else if (wr_data) begin
            nvm_data_d = i_wdata; // RL4
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            nvm_data_q <= DATA_RESET;
        end else begin
            nvm_data_q <= nvm_data_d;
        end
    end

    // software only sets start bits; a set in the finishing cycle wins
    always_comb begin
        nvm_control_d = nvm_control_q;
        if (write_done) begin
            nvm_control_d[CTL_WRITE_START] = 1'b0; // RL7
        end
        if (read_done) begin
            nvm_control_d[CTL_READ_START] = 1'b0; // RL8
        end
        if (wr_ctl) begin
            nvm_control_d[CTL_WRITE_PERMIT] = i_wdata[CTL_WRITE_PERMIT]; // RL7
            nvm_control_d[CTL_READ_PERMIT] = i_wdata[CTL_READ_PERMIT]; // RL8
        end
        if (set_write_start) begin
            nvm_control_d[CTL_WRITE_START] = 1'b1; // RL7
        end
        if (set_read_start) begin
            nvm_control_d[CTL_READ_START] = 1'b1; // RL8
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            nvm_control_q <= CTL_RESET;
        end else begin
            nvm_control_q <= nvm_control_d;
        end
    end

    // read mux is combinational; unmapped reads return zero
    always_comb begin
        o_rdata = 8'h00;
        if (i_direct_rd && sel_addr) begin
            o_rdata = nvm_address_q; // RL6
        end else if (i_direct_rd && sel_data) begin
            o_rdata = nvm_data_q;
        end else if (i_indirect_rd && sel_ctl) begin
            o_rdata = ctl_view(nvm_control_q); // RL3
        end
    end

    // busy straight from state, so it drops on the clearing edge
    assign o_busy = state_q != NVM_IDLE;
endmodule

//--- nvm_pkg.sv
// shared constants for the nvm data access register block
package nvm_pkg;
    localparam int NVM_WORDS_SMALL = 32;
    localparam int NVM_WORDS_LARGE = 64;
    localparam int NVM_ABITS_SMALL = 5;
    localparam int NVM_ABITS_LARGE = 6;
    localparam logic [7:0] NVM_CONTROL_OFS = 8'h40;
    localparam logic [7:0] NVM_CONTROL_BANK = 8'h01;
    localparam logic [7:0] NVM_ADDRESS_OFS = 8'h1e;
    localparam logic [7:0] NVM_DATA_OFS = 8'h1f;
    localparam int CTL_WRITE_PERMIT = 3;
    localparam int CTL_WRITE_START = 2;
    localparam int CTL_READ_PERMIT = 1;
    localparam int CTL_READ_START = 0;
    localparam logic [3:0] CTL_RESET = 4'h0;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int WRITE_TIME_US = 2;
    localparam int CLK_MHZ = 40;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int READ_CYCLES = 2;
    typedef enum logic [1:0] {NVM_IDLE, NVM_READ, NVM_WRITE} nvm_state_e;
endpackage

//--- nvm_array.sv
// byte-wide storage array with registered read port
`timescale 1ns/1ps
module nvm_array
    import nvm_pkg::*;
#(
    parameter int ABITS = NVM_ABITS_LARGE
) (
    input wire logic i_ref_clk,
    input wire logic i_we,
    input wire logic [ABITS-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:(1<<ABITS)-1];
    logic [7:0] rdata_q;

    // contents survive reset, as a non-volatile store would
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        rdata_q <= mem[i_addr];
    end
    assign o_rdata = rdata_q;
endmodule

//--- nvm_props.sv
// port checker for the nvm access registers
`timescale 1ns/1ps
module nvm_props #(parameter bit LARGE = 1'b1) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_direct_rd,
    input wire logic [7:0] i_direct_addr,
    input wire logic i_indirect_wr,
    input wire logic i_indirect_rd,
    input wire logic [7:0] i_indirect_pointer_one,
    input wire logic [7:0] i_bank_select,
    input wire logic [7:0] o_rdata,
    input wire logic o_busy
);
    localparam int ab = LARGE ? 6 : 5;
    wire ir = i_indirect_rd && !i_direct_rd;
    wire ctl = ir && i_indirect_pointer_one == 8'h40 && i_bank_select == 8'h01;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    a_reset_idle: assert property ($past(i_sys_rst) |-> !o_busy)
        else $error("busy out of reset");
    a_addr_upper: assert property (i_direct_rd && !ir && i_direct_addr == 8'h1e |->
        (o_rdata >> ab) == 8'h00) else $error("address upper bits set");
    a_ctl_upper: assert property (ctl |-> o_rdata[7:4] == 4'h0)
        else $error("control upper bits set");
    a_bank_needed: assert property (ir && i_bank_select == 8'h00 |-> o_rdata == 8'h00)
        else $error("control seen outside its bank");
    a_busy_min: assert property ($rose(o_busy) |-> o_busy[*2])
        else $error("busy too short");
    a_busy_bound: assert property ($rose(o_busy) |-> ##[1:81] !o_busy)
        else $error("busy too long");
    // a pending read may start right after a write without a fresh control write
    a_busy_cause: assert property ($rose(o_busy) |-> $past(i_indirect_wr, 2)
        || $past(o_busy, 2)) else $error("busy without control write");
    a_start_shown: assert property (ctl && o_busy |-> (o_rdata[2] || o_rdata[0]))
        else $error("start bit low while busy");
    c_write_run: cover property ($rose(o_busy) ##2 o_busy);
    c_cycle_done: cover property ($fell(o_busy));
    c_ctl_busy: cover property (ctl && o_busy);
endmodule
bind nvm_access_regs nvm_props #(.LARGE(LARGE)) u_props (.i_ref_clk, .i_sys_rst, .i_direct_rd,
    .i_direct_addr, .i_indirect_wr, .i_indirect_rd, .i_indirect_pointer_one, .i_bank_select,
    .o_rdata, .o_busy);

//--- tb_nvm_access_regs.sv
// self-checking bench for the nvm access registers
`timescale 1ns/1ps
module tb_nvm_access_regs;
    import nvm_pkg::*;
    logic i_ref_clk = 1'h0, i_sys_rst = 1'h1, i_direct_wr = 1'h0, i_direct_rd = 1'h0;
    logic i_indirect_wr = 1'h0, i_indirect_rd = 1'h0, o_busy;
    logic [7:0] i_direct_addr = 8'h00, i_indirect_pointer_one = 8'h00, i_wdata = 8'h00;
    logic [7:0] i_bank_select = 8'h01, o_rdata;
    int error_cnt = 0, total_checks = 0, n;
    nvm_access_regs #(.LARGE(1'b1)) dut (.i_ref_clk, .i_sys_rst, .i_direct_wr, .i_direct_rd,
        .i_direct_addr, .i_indirect_wr, .i_indirect_rd, .i_indirect_pointer_one,
        .i_bank_select, .i_wdata, .o_rdata, .o_busy);
    always #12.5 i_ref_clk = ~i_ref_clk;
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        error_cnt += int'(s !== e);
        if (s !== e) $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    endtask
    task automatic summarize;
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // pointer 40h goes the indirect way, every other address direct
    task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        {i_indirect_pointer_one, i_direct_addr, i_wdata} = {a, a, d};
        {i_indirect_wr, i_direct_wr} = {2{!r}} & {a == 8'h40, a != 8'h40};
        {i_indirect_rd, i_direct_rd} = {2{r}} & {a == 8'h40, a != 8'h40};
        #1;
        if (r) check(o_rdata, d);
        @(negedge i_ref_clk);
        {i_indirect_wr, i_direct_wr, i_indirect_rd, i_direct_rd} = 4'h0;
    endtask
    task automatic run;
        @(negedge i_ref_clk);
        for (n = 0; o_busy && n < 200; n++) @(negedge i_ref_clk);
    endtask
    task automatic t_reset;
        acc(1'h1, 8'h1e, 8'h00);
        acc(1'h1, 8'h1f, 8'h00);
        acc(1'h1, 8'h40, 8'h00);
        acc(1'h1, 8'h00, 8'h00);
        i_bank_select = 8'h00;
        acc(1'h0, 8'h40, 8'h0a);
        acc(1'h1, 8'h40, 8'h00);
        i_bank_select = 8'h01;
        acc(1'h1, 8'h40, 8'h00);
    endtask
    task automatic t_write;
        acc(1'h0, 8'h1e, 8'hff);
        acc(1'h1, 8'h1e, 8'h3f);
        acc(1'h0, 8'h1e, 8'h05);
        acc(1'h0, 8'h1f, 8'ha5);
        acc(1'h0, 8'h40, 8'h05);
        acc(1'h1, 8'h40, 8'h00);
        acc(1'h0, 8'h40, 8'h08);
        acc(1'h0, 8'h40, 8'h0c);
        acc(1'h1, 8'h40, 8'h0c);
        run;
        // two busy cycles already spent on the control read above
        check(8'(n), 8'(WRITE_CYCLES - 2));
        acc(1'h1, 8'h40, 8'h08);
    endtask
    task automatic t_read;
        acc(1'h0, 8'h1f, 8'h00);
        acc(1'h0, 8'h40, 8'h02);
        acc(1'h0, 8'h40, 8'h03);
        run;
        check(8'(n), 8'(READ_CYCLES));
        acc(1'h1, 8'h1f, 8'ha5);
        acc(1'h1, 8'h40, 8'h02);
    endtask
    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_sys_rst = 1'h0;
        t_reset;
        t_write;
        t_read;
        summarize;
    end
    initial begin
        #10us;
        error_cnt++;
        summarize;
    end
endmodule
